// file: src/fpec_pkg.sv
/*
 * Constants, state type and register map of the flash program/erase
 * controller. Assumes one 10 MHz clock and a byte-wide flash array.
 */
// Notes on behaviour
// - Program memory is 32768 or 16384 bytes, pages from address zero.
// - A 512-byte page is the erase unit, four rows of 128 bytes.
// - The lowest two bytes hold option bits, not user code.
// - Info enable maps the information page onto FE00h to FFFFh.
// - A programmed read-protect option refuses debugger reads of user code.
// - Write-protect 0 blocks user program/erase; 1 permits; debugger mass erase either way, unless block protect covers a page.
// - Reset leaves the controller locked.
// - Differing page writes relock; matching ones make the page active.
// - Program and erase refused when write-protect is 0 or page protected.
// - After programming, a command other than an erase relocks.
// - Block protect covers pages 0 up to, not including, first unprotected page.
// - 5Eh while locked redirects page select to block protect; next command undoes.
// - Block protect resets to zero; its enable bit sticks until reset.
// - Programming only clears bits; erased bytes read FFh.
// - The CPU stalls while an operation runs, then resumes.
// - After a byte program the active page stays unlocked.
// - 95h when unlocked erases the active page, then relocks.
// - Mass erase only from the debugger: 63h fills memory with FFh, relocks.
// - Mass erase leaves the information page; only page erase clears it.
// - Status codes: locked, key1, key2, unlocked, protect, program, page, mass.
// - Invalid or out-of-order command writes relock.
// - The six-bit page field gives address bits 14 to 9.
`default_nettype none

package fpec_pkg;
   // Bus map, index times four is the byte address
   localparam int unsigned FPEC_ADDR_W = 14;
   localparam int unsigned BYTE_SEL_W = 2;
   localparam logic [11:0] IDX_CMD_STAT = 12'h0ff8;
   localparam logic [11:0] IDX_PAGE_SEL = 12'h0ff9;
   // Commands
   localparam logic [7:0] CMD_KEY1 = 8'h73;
   localparam logic [7:0] CMD_KEY2 = 8'h8c;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
   localparam logic [7:0] CMD_BP_SEL = 8'h5e;
   // Array geometry
   localparam int unsigned MEM_AW = 15;
   localparam int unsigned PAGE_AW = 9;
   localparam int unsigned PAGE_W = 6;
   localparam int unsigned MEM_BYTES = 32768;
   localparam int unsigned PAGE_BYTES = 512;
   localparam int unsigned ROW_BYTES = 128;
   localparam logic [15:0] OPTION_BYTES = 16'h0002;
   localparam logic [15:0] INFO_BASE = 16'hfe00;
   localparam logic [15:0] LAST_BIG = 16'h7fff;
   localparam logic [15:0] LAST_SMALL = 16'h3fff;
   localparam logic [15:0] LAST_PAGE = 16'h01ff;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] RD_REFUSED = 8'h00;
   // Page select and block protect fields
   localparam int unsigned INFO_BIT = 7;
   localparam int unsigned BP_EN_BIT = 7;
   localparam logic [7:0] PS_WMASK = 8'hbf;
   // Status codes
   localparam logic [2:0] ST_LOCKED = 3'h0;
   localparam logic [2:0] ST_KEY1 = 3'h1;
   localparam logic [2:0] ST_KEY2 = 3'h2;
   localparam logic [2:0] ST_UNLOCKED = 3'h3;
   localparam logic [2:0] ST_BP_SEL = 3'h4;
   localparam logic [2:0] ST_PROG = 3'h5;
   localparam logic [2:0] ST_PERASE = 3'h6;
   localparam logic [2:0] ST_MERASE = 3'h7;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned PROG_TIME_NS = 400;
   localparam logic [15:0] PROG_CYCLES = 16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      FS_LOCKED, FS_KEY1, FS_KEY2, FS_UNLOCKED, FS_BP_SEL, FS_PROG, FS_PERASE, FS_MERASE
   } fpec_state_e;
endpackage : fpec_pkg

`default_nettype wire

// file: src/fpec_top.sv
/*
 * Flash program/erase controller: command/status and page select
 * registers on Avalon-MM, lock sequencer, protection and the array.
 * Assumes CPU and debugger accesses arrive synchronous to mclk.
 */
`default_nettype none

module fpec_top
   import fpec_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Avalon-MM register slave
   input wire logic [FPEC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_debug,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Program memory port
   input wire logic [15:0] mem_addr,
   input wire logic mem_read,
   input wire logic mem_write,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_debug,
   output logic [7:0] mem_rdata,
   output logic mem_rvalid,
   // Option bits and variant
   input wire logic write_protect_option,
   input wire logic read_protect_option,
   input wire logic variant_32k,
   // CPU hold
   output logic cpu_stall
);

   fpec_state_e state_reg, state_next;
   logic [7:0] page_select_reg;
   logic [PAGE_W-1:0] active_page_reg;
   logic active_info_reg;
   logic block_protect_enable_reg;
   logic [PAGE_W-1:0] first_unprotected_page_reg;
   logic [15:0] op_cnt_reg;
   logic [15:0] op_last;
   logic [15:0] prog_addr_reg;
   logic [7:0] prog_data_reg;
   logic prog_info_reg;
   logic [7:0] flash_mem [MEM_BYTES];
   logic [7:0] info_mem [PAGE_BYTES];
   logic [11:0] bus_idx;
   logic [7:0] bus_wdata;
   logic [7:0] rd_byte;
   logic bus_req, bus_go, wr_ok, cmd_wr, ps_wr;
   logic op_done, busy_next;
   logic mem_info, mem_in_range, page_prot, prog_ok, prog_go, erase_ok, mass_ok;
   logic [15:0] mem_last;

   // Status code of a state
   function automatic logic [2:0] state_code(input fpec_state_e s);
      case (s)
         FS_LOCKED: state_code = ST_LOCKED;
         FS_KEY1: state_code = ST_KEY1;
         FS_KEY2: state_code = ST_KEY2;
         FS_UNLOCKED: state_code = ST_UNLOCKED;
         FS_BP_SEL: state_code = ST_BP_SEL;
         FS_PROG: state_code = ST_PROG;
         FS_PERASE: state_code = ST_PERASE;
         FS_MERASE: state_code = ST_MERASE;
         default: state_code = ST_LOCKED;
      endcase
   endfunction

   // Bus decode, a request completes when waitrequest is low
   assign bus_idx = avs_address[FPEC_ADDR_W-1:BYTE_SEL_W];
   assign bus_wdata = avs_writedata[7:0];
   assign bus_req = avs_read | avs_write;
   assign bus_go = bus_req & ~avs_waitrequest;
   assign wr_ok = bus_go & avs_write & avs_byteenable[0];
   assign cmd_wr = wr_ok & (bus_idx == IDX_CMD_STAT);
   assign ps_wr = wr_ok & (bus_idx == IDX_PAGE_SEL);

   // Array size and target decode
   assign mem_last = variant_32k ? LAST_BIG : LAST_SMALL;
   assign mem_info = page_select_reg[INFO_BIT] & (mem_addr >= INFO_BASE);
   assign mem_in_range = mem_addr <= mem_last;
   assign page_prot = block_protect_enable_reg & (active_page_reg < first_unprotected_page_reg);

   // Program and erase permission
   always_comb begin
      prog_ok = 1'b0;
      if (write_protect_option) begin
         if (mem_info)
            prog_ok = active_info_reg;
         else
            prog_ok = ~active_info_reg & mem_in_range & ~page_prot
               & (mem_addr[MEM_AW-1:PAGE_AW] == active_page_reg)
               & (mem_debug | (mem_addr >= OPTION_BYTES));
      end
   end
   assign prog_go = mem_write & (state_reg == FS_UNLOCKED) & prog_ok & ~cmd_wr & ~ps_wr;
   assign erase_ok = write_protect_option & (active_info_reg | ~page_prot);
   assign mass_ok = avs_debug & ~(block_protect_enable_reg & (first_unprotected_page_reg != '0));

   // Operation length
   always_comb begin
      case (state_reg)
         FS_PROG: op_last = PROG_CYCLES - 16'h0001;
         FS_PERASE: op_last = LAST_PAGE;
         FS_MERASE: op_last = mem_last;
         default: op_last = '0;
      endcase
   end
   assign op_done = op_cnt_reg == op_last;

   // Next controller state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FS_LOCKED: begin
            if (cmd_wr && bus_wdata == CMD_KEY1)
               state_next = FS_KEY1;
            else if (cmd_wr && bus_wdata == CMD_BP_SEL)
               state_next = FS_BP_SEL;
         end
         FS_KEY1: begin
            if (cmd_wr && bus_wdata == CMD_KEY2)
               state_next = FS_KEY2;
            else if (cmd_wr || ps_wr)
               state_next = FS_LOCKED;
         end
         FS_KEY2: begin
            if (ps_wr)
               state_next = ((bus_wdata & PS_WMASK) == page_select_reg) ? FS_UNLOCKED : FS_LOCKED;
            else if (cmd_wr)
               state_next = FS_LOCKED;
         end
         FS_UNLOCKED: begin
            if (cmd_wr) begin
               if (bus_wdata == CMD_PAGE_ERASE && erase_ok)
                  state_next = FS_PERASE;
               else if (bus_wdata == CMD_MASS_ERASE && mass_ok)
                  state_next = FS_MERASE;
               else
                  state_next = FS_LOCKED;
            end else if (ps_wr)
               state_next = FS_LOCKED;
            else if (prog_go)
               state_next = FS_PROG;
         end
         FS_BP_SEL: begin
            if (cmd_wr)
               state_next = FS_LOCKED;
         end
         FS_PROG: begin
            if (op_done)
               state_next = FS_UNLOCKED;
         end
         FS_PERASE, FS_MERASE: begin
            if (op_done)
               state_next = FS_LOCKED;
         end
         default: state_next = FS_LOCKED;
      endcase
   end
   assign busy_next = (state_next == FS_PROG) | (state_next == FS_PERASE) | (state_next == FS_MERASE);

   // State register and CPU stall
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= FS_LOCKED;
         cpu_stall <= 1'b0;
      end else begin
         state_reg <= state_next;
         cpu_stall <= busy_next;
      end
   end

   // Operation counter, restarts on each state change
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         op_cnt_reg <= '0;
      else if (state_next != state_reg)
         op_cnt_reg <= '0;
      else if (busy_next)
         op_cnt_reg <= op_cnt_reg + 16'h0001;
   end

   // Page select and active page
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         page_select_reg <= '0;
         active_page_reg <= '0;
         active_info_reg <= 1'b0;
      end else if (ps_wr && state_reg != FS_BP_SEL) begin
         page_select_reg <= bus_wdata & PS_WMASK;
         if (state_reg == FS_KEY2 && state_next == FS_UNLOCKED) begin
            active_page_reg <= bus_wdata[PAGE_W-1:0];
            active_info_reg <= bus_wdata[INFO_BIT];
         end
      end
   end

   // Block protect register, enable sticks until reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         block_protect_enable_reg <= 1'b0;
         first_unprotected_page_reg <= '0;
      end else if (ps_wr && state_reg == FS_BP_SEL) begin
         block_protect_enable_reg <= block_protect_enable_reg | bus_wdata[BP_EN_BIT];
         first_unprotected_page_reg <= bus_wdata[PAGE_W-1:0];
      end
   end

   // Program request capture
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prog_addr_reg <= '0;
         prog_data_reg <= '0;
         prog_info_reg <= 1'b0;
      end else if (prog_go) begin
         prog_addr_reg <= mem_addr;
         prog_data_reg <= mem_wdata;
         prog_info_reg <= mem_info;
      end
   end

   // Array writes: program at timer end, erase one byte a cycle
   always_ff @(posedge mclk) begin
      if (state_reg == FS_PROG && op_done) begin
         if (prog_info_reg)
            info_mem[prog_addr_reg[PAGE_AW-1:0]] <= info_mem[prog_addr_reg[PAGE_AW-1:0]] & prog_data_reg;
         else
            flash_mem[prog_addr_reg[MEM_AW-1:0]] <= flash_mem[prog_addr_reg[MEM_AW-1:0]] & prog_data_reg;
      end else if (state_reg == FS_PERASE) begin
         if (active_info_reg)
            info_mem[op_cnt_reg[PAGE_AW-1:0]] <= ERASED;
         else
            flash_mem[{active_page_reg, op_cnt_reg[PAGE_AW-1:0]}] <= ERASED;
      end else if (state_reg == FS_MERASE)
         flash_mem[op_cnt_reg[MEM_AW-1:0]] <= ERASED;
   end

   // Program memory reads, one cycle latency
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata <= '0;
         mem_rvalid <= 1'b0;
      end else begin
         mem_rvalid <= mem_read;
         if (mem_read) begin
            if (mem_info)
               mem_rdata <= info_mem[mem_addr[PAGE_AW-1:0]];
            else if (!mem_in_range)
               mem_rdata <= ERASED;
            else if (mem_debug && !read_protect_option)
               mem_rdata <= RD_REFUSED;
            else
               mem_rdata <= flash_mem[mem_addr[MEM_AW-1:0]];
         end
      end
   end

   // Register read mux, page select address redirected when selected
   always_comb begin
      rd_byte = '0;
      if (bus_idx == IDX_CMD_STAT)
         rd_byte = {5'h00, state_code(state_reg)};
      else if (bus_idx == IDX_PAGE_SEL) begin
         if (state_reg == FS_BP_SEL)
            rd_byte = {block_protect_enable_reg, 1'b0, first_unprotected_page_reg};
         else
            rd_byte = page_select_reg;
      end
   end

   // Bus answer: one wait cycle, data loaded in it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
         if (avs_read && avs_waitrequest)
            avs_readdata <= {24'h00_0000, rd_byte};
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_unlock_mismatch;
      state_reg == FS_KEY2 && ps_wr && (bus_wdata & PS_WMASK) != page_select_reg |=> state_reg == FS_LOCKED;
   endproperty
   a_unlock_mismatch: assert property (p_unlock_mismatch) else $error("mismatched page did not relock");

   property p_wrp_refuse;
      state_reg == FS_UNLOCKED && cmd_wr && bus_wdata == CMD_PAGE_ERASE && !write_protect_option
         |=> state_reg == FS_LOCKED;
   endproperty
   a_wrp_refuse: assert property (p_wrp_refuse) else $error("erase started with write protect");

   property p_relock_cmd;
      state_reg == FS_UNLOCKED && cmd_wr && bus_wdata != CMD_PAGE_ERASE && bus_wdata != CMD_MASS_ERASE
         |=> state_reg == FS_LOCKED;
   endproperty
   a_relock_cmd: assert property (p_relock_cmd) else $error("other command did not relock");

   property p_bp_sticky;
      block_protect_enable_reg |=> block_protect_enable_reg;
   endproperty
   a_bp_sticky: assert property (p_bp_sticky) else $error("block protect enable cleared");

   property p_bp_deselect;
      state_reg == FS_BP_SEL && cmd_wr |=> state_reg == FS_LOCKED ##1 avs_waitrequest;
   endproperty
   a_bp_deselect: assert property (p_bp_deselect) else $error("protect selection not undone");

   property p_prog_time;
      $rose(state_reg == FS_PROG) |-> (cpu_stall && state_reg == FS_PROG)[*4] ##1 state_reg == FS_UNLOCKED;
   endproperty
   a_prog_time: assert property (p_prog_time) else $error("program length or return wrong");

   property p_mass_debug;
      cmd_wr && !avs_debug && state_reg != FS_MERASE |=> state_reg != FS_MERASE;
   endproperty
   a_mass_debug: assert property (p_mass_debug) else $error("mass erase without debugger");

   property p_erase_end;
      state_reg == FS_PERASE && op_done |=> state_reg == FS_LOCKED && !cpu_stall;
   endproperty
   a_erase_end: assert property (p_erase_end) else $error("page erase did not end locked");

   property p_protect;
      prog_go && !mem_info |-> !(block_protect_enable_reg && active_page_reg < first_unprotected_page_reg);
   endproperty
   a_protect: assert property (p_protect) else $error("program on protected page");

   // Sequencer order, stall and timer bounds
   property p_key_order;
      state_reg == FS_KEY1 && cmd_wr && bus_wdata == CMD_KEY2 |=> state_reg == FS_KEY2;
   endproperty
   a_key_order: assert property (p_key_order) else $error("second key not taken");

   property p_unlock_match;
      state_reg == FS_KEY2 && ps_wr && (bus_wdata & PS_WMASK) == page_select_reg |=> state_reg == FS_UNLOCKED;
   endproperty
   a_unlock_match: assert property (p_unlock_match) else $error("matching page did not unlock");

   property p_stall_busy;
      cpu_stall == (state_reg == FS_PROG || state_reg == FS_PERASE || state_reg == FS_MERASE);
   endproperty
   a_stall_busy: assert property (p_stall_busy) else $error("stall differs from busy state");

   property p_bp_redirect;
      state_reg == FS_BP_SEL && ps_wr |=> page_select_reg == $past(page_select_reg);
   endproperty
   a_bp_redirect: assert property (p_bp_redirect) else $error("page select written while redirected");

   property p_prog_refused;
      state_reg == FS_UNLOCKED && mem_write && !cmd_wr && !ps_wr && !prog_ok |=> state_reg == FS_UNLOCKED;
   endproperty
   a_prog_refused: assert property (p_prog_refused) else $error("refused store changed state");

   property p_erase_bound;
      state_reg == FS_PERASE |-> op_cnt_reg <= LAST_PAGE;
   endproperty
   a_erase_bound: assert property (p_erase_bound) else $error("page erase ran past the page");

   property p_locked_idle;
      state_reg == FS_LOCKED |=> !cpu_stall;
   endproperty
   a_locked_idle: assert property (p_locked_idle) else $error("operation started while locked");

endmodule // fpec_top

`default_nettype wire

// file: sim/fpec_host_model.sv
/*
 * CPU and debugger model: Avalon-MM register master and program memory port.
 * Assumes the bench runs mclk and releases reset before the first call.
 */
`default_nettype none

module fpec_host_model
   import fpec_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Avalon-MM master
   output logic [FPEC_ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic avs_debug,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Program memory master
   output logic [15:0] mem_addr,
   output logic mem_read,
   output logic mem_write,
   output logic [7:0] mem_wdata,
   output logic mem_debug,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_rvalid,
   input wire logic cpu_stall
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      {avs_address, avs_read, avs_write, avs_writedata, avs_debug} <= '0;
      {mem_addr, mem_read, mem_write, mem_wdata, mem_debug} <= '0;
   end

   // Register cycle, held until waitrequest seen low; callers order the unlock
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                      input logic dbg, output logic [31:0] rd);
      rd = 32'hxxxx_xxxx;
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h00_0000, wd};
      avs_debug <= dbg;
      forever begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) begin
            rd = avs_readdata;
            break;
         end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // One-cycle memory strobe; read data taken with rvalid
   task automatic mem(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      input logic dbg, output logic [7:0] rd);
      @(posedge mclk);
      mem_addr <= a;
      mem_read <= !wr;
      mem_write <= wr;
      mem_wdata <= d;
      mem_debug <= dbg;
      @(posedge mclk);
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      rd = 8'hxx;
      // Read data taken at the edge where rvalid stands
      if (!wr) begin
         @(posedge mclk);
         if (mem_rvalid === 1'b1) rd = mem_rdata;
      end
   endtask

   // Counts stalled cycles; stops when the stall ends, gives up after lim cycles in all
   task automatic stall_len(input int lim, output logic [15:0] c);
      c = 16'h0000;
      for (int n = 0; n < lim; n++) begin
         @(posedge mclk);
         if (cpu_stall === 1'b1) c++;
         else if (c != 0) break;
      end
   endtask
endmodule // fpec_host_model

`default_nettype wire

// file: sim/flash_program_erase_controller_test.sv
/*
 * Self-checking bench for the flash program/erase controller.
 * Assumes the host model drives all bus and memory traffic.
 */
`default_nettype none

module flash_program_erase_controller_test
   import fpec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk = 0, rst_n = 0, wp = 1, rp = 1, v32 = 0, dbg = 0;
   logic [FPEC_ADDR_W-1:0] a;
   logic rd_s, wr_s, db_s, mr, mw, md, mv, wq, stl;
   logic [31:0] wd, rdat;
   logic [15:0] ma, c;
   logic [7:0] mwd, mrd, b;
   int n_fail = 0, tests_run = 0;

   // Clock from a running oscillator before any operation
   always #50 mclk = ~mclk;

   fpec_top dut (.mclk(mclk), .rst_n(rst_n), .avs_address(a), .avs_read(rd_s), .avs_write(wr_s),
      .avs_writedata(wd), .avs_byteenable(4'h1), .avs_debug(db_s), .avs_readdata(rdat),
      .avs_waitrequest(wq), .mem_addr(ma), .mem_read(mr), .mem_write(mw), .mem_wdata(mwd),
      .mem_debug(md), .mem_rdata(mrd), .mem_rvalid(mv), .write_protect_option(wp),
      .read_protect_option(rp), .variant_32k(v32), .cpu_stall(stl));

   fpec_host_model host (.mclk(mclk), .avs_address(a), .avs_read(rd_s), .avs_write(wr_s),
      .avs_writedata(wd), .avs_debug(db_s), .avs_readdata(rdat), .avs_waitrequest(wq),
      .mem_addr(ma), .mem_read(mr), .mem_write(mw), .mem_wdata(mwd), .mem_debug(md),
      .mem_rdata(mrd), .mem_rvalid(mv), .cpu_stall(stl));

   // Comparison and verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Short-hand bus helpers
   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      logic [31:0] r;
      host.bus(1'b1, i, d, dbg, r);
   endtask
   task automatic rk(input logic [11:0] i, input logic [7:0] e);
      logic [31:0] r;
      host.bus(1'b0, i, 8'h00, dbg, r);
      chk(r, {24'h00_0000, e});
   endtask
   task automatic st(input logic [15:0] ad, input logic [7:0] d, input logic [15:0] e);
      host.mem(1'b1, ad, d, dbg, b);
      host.stall_len(e == 0 ? 8 : 20, c);
      chk(c, e);
   endtask
   task automatic ld(input logic [15:0] ad, input logic [7:0] e);
      host.mem(1'b0, ad, 8'h00, dbg, b);
      chk(b, e);
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
   endtask
   task automatic unlock(input logic [7:0] p);
      wr(IDX_PAGE_SEL, p);
      wr(IDX_CMD_STAT, CMD_KEY1);
      rk(IDX_CMD_STAT, ST_KEY1);
      wr(IDX_CMD_STAT, CMD_KEY2);
      rk(IDX_CMD_STAT, ST_KEY2);
      wr(IDX_PAGE_SEL, p);
      rk(IDX_CMD_STAT, ST_UNLOCKED);
   endtask

   // Scenarios
   task automatic t_erase;
      rk(IDX_CMD_STAT, ST_LOCKED);
      unlock(8'h01);
      wr(IDX_CMD_STAT, CMD_PAGE_ERASE);
      rk(IDX_CMD_STAT, ST_PERASE);
      host.stall_len(2000, c);
      // Status read above lets three stalled cycles pass
      chk(c, PAGE_BYTES - 3);
      rk(IDX_CMD_STAT, ST_LOCKED);
      ld(16'h0204, ERASED);
      ld(16'h03ff, ERASED);
      $display("test page erase done");
   endtask
   task automatic t_prog;
      unlock(8'h01);
      st(16'h0204, 8'ha5, PROG_CYCLES);
      rk(IDX_CMD_STAT, ST_UNLOCKED);
      st(16'h0204, 8'h5a, PROG_CYCLES);
      ld(16'h0204, 8'h00);
      st(16'h0205, 8'h3c, PROG_CYCLES);
      ld(16'h0205, 8'h3c);
      st(16'h0404, 8'h00, 0);
      wr(IDX_CMD_STAT, 8'h00);
      rk(IDX_CMD_STAT, ST_LOCKED);
      st(16'h0206, 8'h00, 0);
      ld(16'h0206, ERASED);
      v32 <= 1'b1;
      unlock(8'h20);
      st(16'h4000, 8'h00, PROG_CYCLES);
      ld(16'h4000, 8'h00);
      v32 <= 1'b0;
      st(16'h4001, 8'h00, 0);
      ld(16'h4000, ERASED);
      wr(IDX_CMD_STAT, 8'h00);
      $display("test program done");
   endtask
   task automatic t_relock;
      wr(IDX_PAGE_SEL, 8'h01);
      wr(IDX_CMD_STAT, CMD_KEY1);
      wr(IDX_CMD_STAT, CMD_KEY2);
      wr(IDX_PAGE_SEL, 8'h02);
      rk(IDX_CMD_STAT, ST_LOCKED);
      wr(IDX_CMD_STAT, CMD_KEY1);
      wr(IDX_CMD_STAT, 8'h11);
      rk(IDX_CMD_STAT, ST_LOCKED);
      wr(IDX_CMD_STAT, CMD_KEY2);
      rk(IDX_CMD_STAT, ST_LOCKED);
      $display("test relock done");
   endtask
   task automatic t_wprot;
      wp <= 1'b0;
      unlock(8'h01);
      st(16'h0207, 8'h00, 0);
      ld(16'h0207, ERASED);
      wr(IDX_CMD_STAT, CMD_PAGE_ERASE);
      rk(IDX_CMD_STAT, ST_LOCKED);
      unlock(8'h01);
      wr(IDX_CMD_STAT, CMD_MASS_ERASE);
      rk(IDX_CMD_STAT, ST_LOCKED);
      $display("test write protect done");
   endtask
   task automatic t_mass;
      // Info page erased and marked before the mass erase
      wp <= 1'b1;
      unlock(8'h80);
      wr(IDX_CMD_STAT, CMD_PAGE_ERASE);
      host.stall_len(2000, c);
      chk(c, PAGE_BYTES);
      unlock(8'h80);
      st(16'hfe10, 8'h5a, PROG_CYCLES);
      wr(IDX_CMD_STAT, 8'h00);
      wp <= 1'b0;
      dbg = 1'b1;
      unlock(8'h01);
      wr(IDX_CMD_STAT, CMD_MASS_ERASE);
      rk(IDX_CMD_STAT, ST_MERASE);
      host.stall_len(20000, c);
      // Status read above lets three stalled cycles pass
      chk(c, 16'h4000 - 16'h0003);
      rk(IDX_CMD_STAT, ST_LOCKED);
      ld(16'h0204, ERASED);
      wr(IDX_PAGE_SEL, 8'h80);
      ld(16'hfe10, 8'h5a);
      wr(IDX_PAGE_SEL, 8'h00);
      dbg = 1'b0;
      wp <= 1'b1;
      $display("test mass erase done");
   endtask
   task automatic t_rdp;
      unlock(8'h01);
      st(16'h0208, 8'h96, PROG_CYCLES);
      rp <= 1'b0;
      dbg = 1'b1;
      ld(16'h0208, RD_REFUSED);
      dbg = 1'b0;
      ld(16'h0208, 8'h96);
      rp <= 1'b1;
      wr(IDX_CMD_STAT, 8'h00);
      $display("test read protect done");
   endtask
   task automatic t_bprot;
      wr(IDX_CMD_STAT, CMD_BP_SEL);
      rk(IDX_CMD_STAT, ST_BP_SEL);
      wr(IDX_PAGE_SEL, 8'h82);
      wr(IDX_PAGE_SEL, 8'h02);
      rk(IDX_PAGE_SEL, 8'h82);
      wr(IDX_CMD_STAT, 8'h00);
      rk(IDX_CMD_STAT, ST_LOCKED);
      unlock(8'h01);
      st(16'h0210, 8'h00, 0);
      wr(IDX_CMD_STAT, 8'h00);
      unlock(8'h02);
      st(16'h0404, 8'h00, PROG_CYCLES);
      do_reset();
      wr(IDX_CMD_STAT, CMD_BP_SEL);
      rk(IDX_PAGE_SEL, 8'h00);
      $display("test block protect done");
   endtask

   // Main sequence
   initial begin
      do_reset();
      rk(IDX_PAGE_SEL, 8'h00);
      t_erase();
      t_prog();
      t_relock();
      t_wprot();
      t_mass();
      t_rdp();
      t_bprot();
      close_out();
   end

   // Watchdog
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      close_out();
   end
endmodule // flash_program_erase_controller_test

`default_nettype wire
